// *** inc/an_ability_pkg.sv ***
// package: register map, fields and carriers of the negotiation ability registers
//
// Behaviour
// [R1] advert register at 4h, resets 0001h
// [R2] software restarts negotiation after early advert writes
// [R3] advert bit 15 read/write, more pages
// [R4] advert bit 13 fault flag; bit 14 reserved
// [R5] advert bits 11, 10 flow control, read/write
// [R6] advert bit 9 resets zero, unsupported
// [R7] advert bits 8..5 speeds, strap reset default one
// [R8] advert bits 4..0 selector, resets 00001
// [R9] partner register at 5h read-only, resets 0000h
// [R10] partner word may change after done with pages
// [R11] partner word mapped bitwise, bit 12 reserved
// [R12] expansion at 6h resets 0064h, bits 6,5 one
// [R13] expansion bit 4 parallel fault, latched, read clears
// [R14] expansion bit 3 partner pages capable, read-only
// [R15] expansion bit 2 reads one, local pages
// [R16] expansion bit 1 page received, read clears
// [R17] expansion bit 0 partner negotiation capable; 15..7 zero
// [R18] basic status bit 5 shows negotiation done
// [R19] reserved, read-only bits ignore writes, read zero
package an_ability_pkg;

	// ************************************************
	// register indices and byte addresses
	// ************************************************
	localparam logic [7:0]  IDX_BASIC      = 8'h01;
	localparam logic [7:0]  IDX_ADVERT     = 8'h04;
	localparam logic [7:0]  IDX_PARTNER    = 8'h05;
	localparam logic [7:0]  IDX_EXPAND     = 8'h06;
	localparam logic [7:0]  ADDR_BASIC     = IDX_BASIC << 2;
	localparam logic [7:0]  ADDR_ADVERT    = IDX_ADVERT << 2;
	localparam logic [7:0]  ADDR_PARTNER   = IDX_PARTNER << 2;
	localparam logic [7:0]  ADDR_EXPAND    = IDX_EXPAND << 2;
	localparam logic [7:0]  ADDR_IRQ_STAT  = 8'h40;
	localparam logic [7:0]  ADDR_IRQ_MASK  = 8'h44;
	localparam logic [7:0]  ADDR_CTRL      = 8'h48;

	// ************************************************
	// reset values and masks
	// ************************************************
	localparam logic [15:0] ADVERT_RST     = 16'h0001;
	localparam logic [15:0] PARTNER_RST    = 16'h0000;
	localparam logic [15:0] EXPAND_RST     = 16'h0064;
	localparam logic [15:0] ADVERT_WR_MASK = 16'hBDFF;
	localparam logic [15:0] PARTNER_MASK   = 16'hEFFF;
	localparam logic [3:0]  STRAP_DEFAULT  = 4'hF;
	localparam logic [4:0]  SEL_IEEE8023   = 5'h01;

	// ************************************************
	// field positions
	// ************************************************
	localparam int B_MORE_PAGES   = 15;
	localparam int B_ADV_RSVD     = 14;
	localparam int B_FAULT        = 13;
	localparam int B_ASYM         = 11;
	localparam int B_FLOW         = 10;
	localparam int B_T4           = 9;
	localparam int B_SPEED_LO     = 5;
	localparam int B_SEL_HI       = 4;
	localparam int E_LOC_VALID    = 6;
	localparam int E_STOR_SEL     = 5;
	localparam int E_PD_FAULT     = 4;
	localparam int E_PART_PAGES   = 3;
	localparam int E_LOCAL_PAGES  = 2;
	localparam int E_PAGE_RX      = 1;
	localparam int E_PART_NEG     = 0;
	localparam int S_DONE         = 5;
	localparam int C_RESTART      = 0;
	localparam int NUM_IRQ        = 4;
	localparam int IRQ_PD_FAULT   = 0;
	localparam int IRQ_PAGE_RX    = 1;
	localparam int IRQ_DONE       = 2;
	localparam int IRQ_WORD       = 3;

	// ************************************************
	// types
	// ************************************************
	typedef enum logic [0:0] {
		ST_STRAP = 1'b0,
		ST_RUN   = 1'b1
	} init_state_t;

	typedef struct packed {
		logic        word_valid;
		logic [15:0] word;
		logic        pages_capable;
		logic        neg_capable;
		logic        pd_fault;
		logic        page_rx;
	} partner_in_t;

	typedef struct packed {
		logic       valid;
		logic [3:0] ability;
	} strap_t;

endpackage

// *** design/latch_high_flag.sv ***
// latched-high flag: hardware set wins over clear
`timescale 1ns/1ps
module latch_high_flag
(
	input  wire logic pclk,
	input  wire logic presetn,
	input  wire logic set,
	input  wire logic clr,
	output logic      q
);
	logic q_ff;

	// ************************************************
	// sticky bit
	// ************************************************
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			q_ff <= 1'b0;
		else if (set)
			q_ff <= 1'b1;
		else if (clr)
			q_ff <= 1'b0;
	end

	assign q = q_ff;

endmodule

// *** design/autoneg_ability_registers.sv ***
// negotiation ability, partner ability and expansion registers with apb slave
`timescale 1ns/1ps
module autoneg_ability_registers
(
	input  wire logic                        pclk,
	input  wire logic                        presetn,
	input  wire logic [7:0]                  paddr,
	input  wire logic                        psel,
	input  wire logic                        penable,
	input  wire logic                        pwrite,
	input  wire logic [31:0]                 pwdata,
	output logic      [31:0]                 prdata,
	output logic                             pready,
	output logic                             pslverr,
	input  wire logic                        negotiation_done,
	input  wire an_ability_pkg::partner_in_t partner,
	input  wire an_ability_pkg::strap_t      strap,
	output logic      [15:0]                 advert_word,
	output logic                             an_restart,
	output logic                             irq
);
	import an_ability_pkg::*;

	init_state_t         init_ff;
	logic [15:0]         advert_ff;
	logic [15:0]         partner_ff;
	logic                part_pages_ff;
	logic                part_neg_ff;
	logic                done_prev_ff;
	logic [NUM_IRQ-1:0]  mask_ff;
	logic                irq_ff;
	logic                restart_ff;
	logic [31:0]         prdata_ff;
	logic [1:0]          rc_seen_ff;
	logic                pd_fault_q;
	logic                page_rx_q;
	logic [NUM_IRQ-1:0]  irq_stat;
	logic [NUM_IRQ-1:0]  irq_event;
	logic [31:0]         nxt_prdata;
	logic                addr_ok;
	logic                setup_rd;
	logic                acc;
	logic                acc_wr;
	logic                acc_rd;
	logic                wr_advert;
	logic                wr_irq_stat;
	logic                wr_irq_mask;
	logic                wr_ctrl;
	logic                rd_expand_clr;
	logic                load_ok;
	logic [15:0]         expand_word;
	logic [15:0]         basic_word;

	// ************************************************
	// apb phases and address decode
	// ************************************************
	assign setup_rd = psel & ~penable & ~pwrite;
	assign acc      = psel & penable;
	assign acc_wr   = acc & pwrite;
	assign acc_rd   = acc & ~pwrite;

	always_comb
	begin
		wr_advert     = 1'b0;
		wr_irq_stat   = 1'b0;
		wr_irq_mask   = 1'b0;
		wr_ctrl       = 1'b0;
		rd_expand_clr = 1'b0;
		if (paddr == ADDR_ADVERT)
			wr_advert = acc_wr;
		else if (paddr == ADDR_EXPAND)
			rd_expand_clr = acc_rd;
		else if (paddr == ADDR_IRQ_STAT)
			wr_irq_stat = acc_wr;
		else if (paddr == ADDR_IRQ_MASK)
			wr_irq_mask = acc_wr;
		else if (paddr == ADDR_CTRL)
			wr_ctrl = acc_wr;
	end

	// ************************************************
	// strap capture after reset release
	// ************************************************
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			init_ff <= ST_STRAP;
		else
			init_ff <= ST_RUN;
	end

	// ************************************************
	// local advertisement register
	// ************************************************
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			advert_ff <= ADVERT_RST; // [R1] [R3] [R6] [R8]
		else
		begin
			case (init_ff)
				ST_STRAP:
				begin
					if (strap.valid)
						advert_ff[B_SPEED_LO +: 4] <= strap.ability; // [R7]
					else
						advert_ff[B_SPEED_LO +: 4] <= STRAP_DEFAULT; // [R7]
				end
				ST_RUN:
				begin
					// bits 15,13,12,11,10,8..0 writable; 14 and 9 stay zero
					if (wr_advert)
						advert_ff <= pwdata[15:0] & ADVERT_WR_MASK; // [R3] [R4] [R5] [R6] [R8] [R19]
				end
				default:
					advert_ff <= advert_ff;
			endcase
		end
	end

	assign advert_word = advert_ff; // [R1]

	// ************************************************
	// link partner ability register
	// ************************************************
	// after done the word only moves while more pages are in play
	assign load_ok = partner.word_valid & (~negotiation_done | advert_ff[B_MORE_PAGES]); // [R10]

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			partner_ff <= PARTNER_RST; // [R9]
		else if (load_ok)
			partner_ff <= partner.word & PARTNER_MASK; // [R9] [R11]
	end

	// ************************************************
	// expansion status
	// ************************************************
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			part_pages_ff <= 1'b0;
			part_neg_ff   <= 1'b0;
		end
		else
		begin
			part_pages_ff <= partner.pages_capable; // [R14]
			part_neg_ff   <= partner.neg_capable;   // [R17]
		end
	end

	// only bits shown by the read are cleared, so a late event survives
	latch_high_flag u_pd_fault
	(
		.pclk    (pclk),
		.presetn (presetn),
		.set     (partner.pd_fault),                  // [R13]
		.clr     (rd_expand_clr & rc_seen_ff[1]),     // [R13]
		.q       (pd_fault_q)
	);

	latch_high_flag u_page_rx
	(
		.pclk    (pclk),
		.presetn (presetn),
		.set     (partner.page_rx),                   // [R16]
		.clr     (rd_expand_clr & rc_seen_ff[0]),     // [R16]
		.q       (page_rx_q)
	);

	always_comb
	begin
		expand_word                = EXPAND_RST; // [R12] [R15] [R17]
		expand_word[E_PD_FAULT]    = pd_fault_q;    // [R13]
		expand_word[E_PART_PAGES]  = part_pages_ff; // [R14]
		expand_word[E_PAGE_RX]     = page_rx_q;     // [R16]
		expand_word[E_PART_NEG]    = part_neg_ff;   // [R17]
	end

	always_comb
	begin
		basic_word         = 16'h0000;
		basic_word[S_DONE] = negotiation_done; // [R18]
	end

	// ************************************************
	// interrupt status, mask and output
	// ************************************************
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			done_prev_ff <= 1'b0;
		else
			done_prev_ff <= negotiation_done;
	end

	always_comb
	begin
		irq_event               = '0;
		irq_event[IRQ_PD_FAULT] = partner.pd_fault;
		irq_event[IRQ_PAGE_RX]  = partner.page_rx;
		irq_event[IRQ_DONE]     = negotiation_done & ~done_prev_ff;
		irq_event[IRQ_WORD]     = load_ok;
	end

	genvar gi;
	generate
		for (gi = 0; gi < NUM_IRQ; gi = gi + 1)
		begin : g_irq
			latch_high_flag u_flag
			(
				.pclk    (pclk),
				.presetn (presetn),
				.set     (irq_event[gi]),
				.clr     (wr_irq_stat & pwdata[gi]),
				.q       (irq_stat[gi])
			);
		end
	endgenerate

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			mask_ff <= '0;
		else if (wr_irq_mask)
			mask_ff <= pwdata[NUM_IRQ-1:0];
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			irq_ff <= 1'b0;
		else
			irq_ff <= |(irq_stat & mask_ff);
	end

	assign irq = irq_ff;

	// ************************************************
	// restart request pulse
	// ************************************************
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			restart_ff <= 1'b0;
		else
			restart_ff <= wr_ctrl & pwdata[C_RESTART]; // [R2]
	end

	assign an_restart = restart_ff;

	// ************************************************
	// read mux and read data register
	// ************************************************
	always_comb
	begin
		nxt_prdata = 32'h0000_0000;
		addr_ok    = 1'b1;
		if (paddr == ADDR_BASIC)
			nxt_prdata[15:0] = basic_word;
		else if (paddr == ADDR_ADVERT)
			nxt_prdata[15:0] = advert_ff;
		else if (paddr == ADDR_PARTNER)
			nxt_prdata[15:0] = partner_ff;
		else if (paddr == ADDR_EXPAND)
			nxt_prdata[15:0] = expand_word;
		else if (paddr == ADDR_IRQ_STAT)
			nxt_prdata[NUM_IRQ-1:0] = irq_stat;
		else if (paddr == ADDR_IRQ_MASK)
			nxt_prdata[NUM_IRQ-1:0] = mask_ff;
		else if (paddr == ADDR_CTRL)
			nxt_prdata = 32'h0000_0000;
		else
			addr_ok = 1'b0;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			prdata_ff <= 32'h0000_0000;
		else if (setup_rd)
			prdata_ff <= nxt_prdata;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			rc_seen_ff <= 2'b00;
		else if (setup_rd)
			rc_seen_ff <= {pd_fault_q, page_rx_q};
	end

	assign prdata  = prdata_ff;
	assign pready  = 1'b1;
	assign pslverr = acc & ~addr_ok;

	// ************************************************
	// checks
	// ************************************************
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	AST_ADV_RSVD_ZERO: // [R4]
	assert property (advert_ff[B_ADV_RSVD] == 1'b0)
	else $error("advert reserved bit 14 set");

	AST_T4_ZERO: // [R6]
	assert property (advert_ff[B_T4] == 1'b0)
	else $error("advert t4 bit set");

	AST_ADV_WRITE: // [R3]
	assert property (wr_advert && init_ff == ST_RUN
		|=> advert_ff == ($past(pwdata[15:0]) & ADVERT_WR_MASK))
	else $error("advert write not stored");

	AST_FLOW_FIELDS: // [R5]
	assert property (wr_advert && init_ff == ST_RUN
		|=> advert_ff[B_ASYM:B_FLOW] == $past(pwdata[B_ASYM:B_FLOW]))
	else $error("flow control bits not written");

	AST_PARTNER_LOAD: // [R9]
	assert property (load_ok |=> partner_ff == ($past(partner.word) & PARTNER_MASK))
	else $error("partner word not loaded");

	AST_PARTNER_HOLD: // [R10]
	assert property (negotiation_done && !advert_ff[B_MORE_PAGES] |=> $stable(partner_ff))
	else $error("partner word changed after done");

	AST_PARTNER_RSVD: // [R11]
	assert property (partner_ff[12] == 1'b0)
	else $error("partner reserved bit set");

	AST_PD_LATCH: // [R13]
	assert property (partner.pd_fault |=> pd_fault_q ##1 (pd_fault_q || $past(rd_expand_clr && rc_seen_ff[1])))
	else $error("parallel fault not latched");

	AST_PAGE_CLEAR: // [R16]
	assert property (rd_expand_clr && rc_seen_ff[0] && !partner.page_rx |=> !page_rx_q)
	else $error("page received not cleared by read");

	AST_EXP_READ: // [R12]
	assert property (setup_rd && paddr == ADDR_EXPAND
		|=> prdata[E_LOC_VALID] && prdata[E_STOR_SEL] && prdata[E_LOCAL_PAGES] && prdata[31:7] == '0)
	else $error("expansion constant bits wrong");

	AST_DONE_READ: // [R18]
	assert property (setup_rd && paddr == ADDR_BASIC |=> prdata[S_DONE] == $past(negotiation_done))
	else $error("done bit mismatch");

	AST_IRQ_LEVEL:
	assert property ((|(irq_stat & mask_ff)) |=> irq)
	else $error("irq not raised");

endmodule

// *** sim/link_partner_model.sv ***
// link partner model: received base word, page events and negotiation levels
`timescale 1ns/1ps
module link_partner_model
(
	input  wire logic                   pclk,
	output an_ability_pkg::partner_in_t partner,
	output logic                        negotiation_done
);
	import an_ability_pkg::*;

	// ********************************
	// idle values
	// ********************************
	initial
	begin
		partner = '0;
		partner.word = 16'h5A5A;
		negotiation_done = 1'b0;
	end

	// ********************************
	// traffic from the far side
	// ********************************
	// word shows its inverse once the strobe is gone
	task automatic send_word(input logic [15:0] w);
		@(posedge pclk);
		partner.word_valid <= 1'b1;
		partner.word       <= w;
		@(posedge pclk);
		partner.word_valid <= 1'b0;
		partner.word       <= ~w;
	endtask

	task automatic pulse(input logic fault, input logic page);
		@(posedge pclk);
		partner.pd_fault <= fault;
		partner.page_rx  <= page;
		@(posedge pclk);
		partner.pd_fault <= 1'b0;
		partner.page_rx  <= 1'b0;
	endtask

	task automatic set_levels(input logic pages, input logic neg, input logic done);
		@(posedge pclk);
		partner.pages_capable <= pages;
		partner.neg_capable   <= neg;
		negotiation_done      <= done;
	endtask
endmodule

// *** sim/autoneg_ability_registers_tb.sv ***
// testbench: ability register bank over apb with a link partner model
`timescale 1ns/1ps
module autoneg_ability_registers_tb;
	import an_ability_pkg::*;

	// ********************************
	// signals
	// ********************************
	typedef struct packed { logic [7:0] a; logic [31:0] d; } row_t;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
	logic        negotiation_done, an_restart, irq;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [15:0] advert_word;
	logic [1:0]  cnt;
	partner_in_t partner;
	strap_t      strap;
	row_t        rows [7];
	int          err_count = 0;
	int          n_compared = 0;
	int          cycles = 0;

	autoneg_ability_registers dut (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
		.penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .negotiation_done(negotiation_done), .partner(partner), .strap(strap),
		.advert_word(advert_word), .an_restart(an_restart), .irq(irq));
	link_partner_model lp (.pclk(pclk), .partner(partner), .negotiation_done(negotiation_done));

	// ********************************
	// clock and timeout
	// ********************************
	initial
	begin
		pclk = 1'b0;
		forever #25 pclk = ~pclk;
	end

	always @(posedge pclk)
	begin
		cycles <= cycles + 1;
		if (cycles == 5000)
		begin
			err_count++;
			results();
		end
	end

	// ********************************
	// tasks
	// ********************************
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel    <= 1'b1;
		penable <= 1'b0;
		paddr   <= a;
		pwrite  <= w;
		pwdata  <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1)
			@(posedge pclk);
		rd = prdata;
		err = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		n_compared++;
		if (g !== e)
		begin
			$display("MISMATCH %s expected %h seen %h", n, e, g);
			err_count++;
		end
	endtask

	task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0000_0000);
		chk($sformatf("read %h", a), e, rd);
		chk("pslverr", 32'h0, {31'h0, err});
	endtask

	task automatic do_reset(input strap_t s);
		@(posedge pclk);
		presetn <= 1'b0;
		strap   <= s;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
	endtask

	task automatic results();
		$display("compared %0d mismatches %0d", n_compared, err_count);
		if (err_count == 0 && n_compared > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	// ********************************
	// main sequence
	// ********************************
	initial
	begin
		rows[0] = {ADDR_BASIC, 32'h0000_0000};
		rows[1] = {ADDR_ADVERT, 32'h0000_01E1};
		rows[2] = {ADDR_PARTNER, 32'h0000_0000};
		rows[3] = {ADDR_EXPAND, 32'h0000_0064};
		rows[4] = {ADDR_IRQ_STAT, 32'h0000_0000};
		rows[5] = {ADDR_IRQ_MASK, 32'h0000_0000};
		rows[6] = {ADDR_CTRL, 32'h0000_0000};
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0000_0000;
		strap = '0;
		do_reset('0);
		foreach (rows[i])
			rdchk(rows[i].a, rows[i].d);
		chk("advert_word", 32'h01E1, {16'h0000, advert_word});
		$display("test reset values done");
		apb(1'b1, ADDR_ADVERT, 32'hFFFF_FFFF);
		rdchk(ADDR_ADVERT, 32'h0000_BDFF);
		chk("advert_word", 32'hBDFF, {16'h0000, advert_word});
		apb(1'b1, ADDR_ADVERT, 32'h0000_0000);
		rdchk(ADDR_ADVERT, 32'h0000_0000);
		apb(1'b1, ADDR_CTRL, 32'h0000_0001);
		cnt = 2'b00;
		repeat (3)
		begin
			#1 cnt = cnt + an_restart;
			@(posedge pclk);
		end
		chk("restart pulses", 32'h1, {30'h0, cnt});
		$display("test advert write done");
		apb(1'b1, ADDR_PARTNER, 32'h0000_FFFF);
		rdchk(ADDR_PARTNER, 32'h0000_0000);
		lp.send_word(16'hFFFF);
		rdchk(ADDR_PARTNER, 32'h0000_EFFF);
		lp.set_levels(1'b0, 1'b0, 1'b1);
		rdchk(ADDR_BASIC, 32'h0000_0020);
		lp.send_word(16'h1234);
		rdchk(ADDR_PARTNER, 32'h0000_EFFF);
		apb(1'b1, ADDR_ADVERT, 32'h0000_8001);
		lp.send_word(16'h1234);
		rdchk(ADDR_PARTNER, 32'h0000_0234);
		rdchk(ADDR_IRQ_STAT, 32'h0000_000C);
		$display("test partner word done");
		lp.set_levels(1'b1, 1'b1, 1'b1);
		lp.pulse(1'b1, 1'b1);
		rdchk(ADDR_EXPAND, 32'h0000_007F);
		rdchk(ADDR_EXPAND, 32'h0000_006D);
		apb(1'b1, ADDR_EXPAND, 32'h0000_FFFF);
		rdchk(ADDR_EXPAND, 32'h0000_006D);
		$display("test expansion done");
		apb(1'b1, ADDR_IRQ_STAT, 32'h0000_000F);
		apb(1'b1, ADDR_IRQ_MASK, 32'h0000_0001);
		rdchk(ADDR_IRQ_MASK, 32'h0000_0001);
		lp.pulse(1'b0, 1'b1);
		repeat (2) @(posedge pclk);
		chk("irq masked", 32'h0, {31'h0, irq});
		lp.pulse(1'b1, 1'b0);
		repeat (2) @(posedge pclk);
		chk("irq raised", 32'h1, {31'h0, irq});
		rdchk(ADDR_IRQ_STAT, 32'h0000_0003);
		apb(1'b1, ADDR_IRQ_STAT, 32'h0000_0001);
		repeat (2) @(posedge pclk);
		chk("irq cleared", 32'h0, {31'h0, irq});
		rdchk(ADDR_IRQ_STAT, 32'h0000_0002);
		$display("test interrupt done");
		apb(1'b0, 8'h80, 32'h0000_0000);
		chk("pslverr", 32'h1, {31'h0, err});
		chk("unmapped data", 32'h0, rd);
		do_reset('{valid: 1'b1, ability: 4'hA});
		rdchk(ADDR_ADVERT, 32'h0000_0141);
		rdchk(ADDR_EXPAND, 32'h0000_006D);
		$display("test strap reset done");
		results();
	end
endmodule
